/* design/irq_regs_map.svh */
/*
 * Holds the register addresses, field positions, reset values and source
 * order numbers of the interrupt enable and priority register set.
 * Assumes it is included by its bare name wherever these values are needed.
 */
`ifndef IRQ_REGS_MAP_SVH
`define IRQ_REGS_MAP_SVH

// ==========================================================================
// register addresses on the special-function register port
`define ENABLE_MAIN_ADDR 8'hA8
`define PRIORITY_MAIN_ADDR 8'hB8
`define ENABLE_EXT_ADDR 8'hE6
`define PRIORITY_EXT_ADDR 8'hF6

// ==========================================================================
// reset values
`define ENABLE_MAIN_RESET 8'h00
`define PRIORITY_MAIN_RESET 8'h80
`define ENABLE_EXT_RESET 8'h00
`define PRIORITY_EXT_RESET 8'h00
`define UNMAPPED_READ 8'h00

// ==========================================================================
// field positions
`define GLOBAL_GATE_BIT 7
`define PRIORITY_UNUSED_BIT 7

// ==========================================================================
// fixed source order numbers, lowest number wins within a level
`define SRC_COUNT 15
`define SRC_EXT_PIN0 4'h0
`define SRC_TIMER0 4'h1
`define SRC_EXT_PIN1 4'h2
`define SRC_TIMER1 4'h3
`define SRC_UART 4'h4
`define SRC_TIMER2 4'h5
`define SRC_SERIAL_PORT 4'h6
`define SRC_WINDOW 4'h7
`define SRC_CONVERSION 4'h8
`define SRC_COUNTER_ARRAY 4'h9
`define SRC_CMP_FALL 4'hA
`define SRC_CMP_RISE 4'hB
`define SRC_LIN 4'hC
`define SRC_REGULATOR 4'hD
`define SRC_PORT_MATCH 4'hE

`endif

/* design/irq_regs_pkg.sv */
/*
 * Holds the types of the interrupt enable and priority register set.
 * Assumes the map header supplies every number.
 */
`default_nettype none

package irq_regs_pkg;

    // ======================================================================
    // service nesting of the cpu
    typedef enum logic [1:0] {
        SERV_IDLE = 2'b00,
        SERV_LOW = 2'b01,
        SERV_HIGH = 2'b10,
        SERV_HIGH_OVER_LOW = 2'b11
    } serv_state_t;

    // ======================================================================
    // whole state of the control module
    typedef struct packed {
        logic [7:0] enable_main;
        logic [6:0] priority_main;
        logic [7:0] enable_ext;
        logic [7:0] priority_ext;
        serv_state_t serv;
        logic holdoff;
        logic req;
        logic [3:0] idx;
        logic level;
        logic [7:0] rdata;
    } ctrl_state_t;

endpackage : irq_regs_pkg

`default_nettype wire

/* design/irq_resolve_if.sv */
/*
 * Carries gated pending requests and their levels to the priority
 * resolver and the winning source back.
 * Assumes both ends run on the same clock; the path is combinational.
 */
`timescale 1ns/100ps
`default_nettype none

interface irq_resolve_if;
    logic [14:0] pending;
    logic [14:0] level;
    logic grant_valid;
    logic [3:0] grant_idx;
    logic grant_level;

    modport ctrl (
        output pending,
        output level,
        input grant_valid,
        input grant_idx,
        input grant_level
    );

    modport arb (
        input pending,
        input level,
        output grant_valid,
        output grant_idx,
        output grant_level
    );
endinterface : irq_resolve_if

`default_nettype wire

/* design/irq_priority_resolver.sv */
/*
 * Picks one source among gated pending requests: any high-level request
 * beats every low-level one, and within a level the lowest order number wins.
 * Assumes inputs are already masked; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

module irq_priority_resolver (
    // resolver side of the carrier
    irq_resolve_if.arb res
);

    // ======================================================================
    // fixed-order search, low level first, then high level overwrites it
    always_comb begin
        res.grant_valid = 1'b0;
        res.grant_idx = 4'h0;
        res.grant_level = 1'b0;
        // walking downward lets the lowest number overwrite
        for (int i = 14; i >= 0; i--) begin
            if (res.pending[i] && !res.level[i] && !res.grant_level) begin
                res.grant_valid = 1'b1;
                res.grant_idx = 4'(i);
            end
        end
        for (int i = 14; i >= 0; i--) begin
            if (res.pending[i] && res.level[i]) begin // RULE23
                res.grant_valid = 1'b1;
                res.grant_idx = 4'(i);
                res.grant_level = 1'b1;
            end
        end
    end

endmodule : irq_priority_resolver

`default_nettype wire

/* design/irq_mask_priority_regs.sv */
/*
 * Holds the interrupt enable and priority register set of an 8051-style
 * core, gates the peripheral requests and presents one resolved request
 * with its source number and level to the cpu vectoring logic.
 * Assumes every request flag is a level from logic on sys_clk_i, held by
 * its peripheral until software or the vectoring logic clears it there.
 */
//
// Contract
// RULE1: global gate at 0 blocks all sources; at 1 each mask decides.
// RULE2: main enable bit 6 masks serial peripheral port requests.
// RULE3: main enable bit 5 gates timer 2; either overflow flag requests.
// RULE4: main enable bit 4 masks the uart request.
// RULE5: main enable bit 3 gates the timer 1 overflow request.
// RULE6: main enable bit 1 gates the timer 0 overflow request.
// RULE7: main enable bit 2 masks external pin 1, bit 0 pin 0.
// RULE8: main priority top bit reads one and ignores writes.
// RULE9: main priority bits 6..4 set serial port, timer 2, uart level.
// RULE10: main priority bits 3..0 set timer 1, pin 1, timer 0, pin 0.
// RULE11: extended enable bit 7 masks port match.
// RULE12: extended enable bit 6 masks regulator dropout.
// RULE13: extended enable bit 5 masks the lin unit.
// RULE14: extended enable bits 4 and 3 mask comparator rise and fall.
// RULE15: extended enable bit 2 masks the counter array.
// RULE16: extended enable bit 1 gates conversion done.
// RULE17: extended enable bit 0 gates window compare.
// RULE18: extended priority bits 7..5 set port match, regulator, lin level.
// RULE19: extended priority bits 4 and 3 set comparator rise, fall level.
// RULE20: extended priority bits 2..0 set counter array, conversion, window.
// RULE21: pending requests are sampled and resolved every clock.
// RULE22: after a return, one more instruction runs before the next vector.
// RULE23: lowest order number wins per level; high preempts low service.
// RULE24: masks gate delivery only; source flags are never touched.
`timescale 1ns/100ps
`default_nettype none

`include "irq_regs_map.svh"

module irq_mask_priority_regs (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // special-function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    // peripheral request flags
    input wire logic ext_pin0_request_i,
    input wire logic timer0_overflow_flag_i,
    input wire logic ext_pin1_request_i,
    input wire logic timer1_overflow_flag_i,
    input wire logic uart_request_i,
    input wire logic timer2_low_overflow_flag_i,
    input wire logic timer2_high_overflow_flag_i,
    input wire logic serial_port_request_i,
    input wire logic window_compare_flag_i,
    input wire logic conversion_done_flag_i,
    input wire logic counter_array_request_i,
    input wire logic comparator_fall_request_i,
    input wire logic comparator_rise_request_i,
    input wire logic lin_unit_request_i,
    input wire logic regulator_drop_request_i,
    input wire logic port_match_request_i,
    // cpu vectoring logic
    input wire logic cpu_vector_ack_i,
    input wire logic cpu_reti_i,
    input wire logic cpu_instr_done_i,
    output logic irq_req_o,
    output logic [3:0] irq_idx_o,
    output logic irq_level_o,
    // register fields seen by other logic
    output logic global_irq_gate_o
);

    // ======================================================================
    // state
    irq_regs_pkg::ctrl_state_t st_reg;
    irq_regs_pkg::ctrl_state_t st_next;

    logic [14:0] src_vec;
    logic [14:0] mask_vec;
    logic [14:0] level_vec;
    logic [14:0] gated_vec;
    logic global_irq_gate;
    logic grant_allowed;

    irq_resolve_if res ();

    // ======================================================================
    // source gathering in fixed order
    assign src_vec = {
        port_match_request_i,
        regulator_drop_request_i,
        lin_unit_request_i,
        comparator_rise_request_i,
        comparator_fall_request_i,
        counter_array_request_i,
        conversion_done_flag_i,
        window_compare_flag_i,
        serial_port_request_i,
        timer2_low_overflow_flag_i | timer2_high_overflow_flag_i, // RULE3
        uart_request_i,
        timer1_overflow_flag_i,
        ext_pin1_request_i,
        timer0_overflow_flag_i,
        ext_pin0_request_i
    };

    // order numbers line up with enable bits of both registers
    assign mask_vec = {st_reg.enable_ext, st_reg.enable_main[6:0]}; // RULE2 RULE4 RULE5 RULE6 RULE7 RULE11 RULE12 RULE13 RULE14 RULE15 RULE16 RULE17
    assign level_vec = {st_reg.priority_ext, st_reg.priority_main}; // RULE9 RULE10 RULE18 RULE19 RULE20
    assign global_irq_gate = st_reg.enable_main[`GLOBAL_GATE_BIT];

    // ======================================================================
    // per-source gating; flags themselves are never cleared here
    genvar g;
    generate
        for (g = 0; g < `SRC_COUNT; g++) begin : gate_gen
            assign gated_vec[g] = global_irq_gate & mask_vec[g] & src_vec[g]; // RULE1 RULE24
        end
    endgenerate

    assign res.pending = gated_vec;
    assign res.level = level_vec;

    irq_priority_resolver resolver_u (
        .res(res)
    );

    // ======================================================================
    // nesting: low service admits only high, high service admits none
    always_comb begin
        grant_allowed = 1'b0;
        unique case (st_reg.serv)
            irq_regs_pkg::SERV_IDLE: grant_allowed = 1'b1;
            irq_regs_pkg::SERV_LOW: grant_allowed = res.grant_level; // RULE23
            irq_regs_pkg::SERV_HIGH: grant_allowed = 1'b0;
            irq_regs_pkg::SERV_HIGH_OVER_LOW: grant_allowed = 1'b0;
        endcase
    end

    // ======================================================================
    // next state
    always_comb begin
        st_next = st_reg;

        // register writes
        if (sfr_wr_i) begin
            unique case (sfr_addr_i)
                `ENABLE_MAIN_ADDR: st_next.enable_main = sfr_wdata_i;
                `PRIORITY_MAIN_ADDR: st_next.priority_main = sfr_wdata_i[6:0]; // RULE8
                `ENABLE_EXT_ADDR: st_next.enable_ext = sfr_wdata_i;
                `PRIORITY_EXT_ADDR: st_next.priority_ext = sfr_wdata_i;
                default: ;
            endcase
        end

        // register reads, answered one cycle later
        if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                `ENABLE_MAIN_ADDR: st_next.rdata = st_reg.enable_main;
                `PRIORITY_MAIN_ADDR: st_next.rdata = {1'b1, st_reg.priority_main}; // RULE8
                `ENABLE_EXT_ADDR: st_next.rdata = st_reg.enable_ext;
                `PRIORITY_EXT_ADDR: st_next.rdata = st_reg.priority_ext;
                default: st_next.rdata = `UNMAPPED_READ;
            endcase
        end

        // nesting level follows vector takes and returns
        if (cpu_vector_ack_i && st_reg.req) begin
            unique case (st_reg.serv)
                irq_regs_pkg::SERV_IDLE:
                    st_next.serv = st_reg.level ? irq_regs_pkg::SERV_HIGH
                                                : irq_regs_pkg::SERV_LOW;
                irq_regs_pkg::SERV_LOW: st_next.serv = irq_regs_pkg::SERV_HIGH_OVER_LOW; // RULE23
                irq_regs_pkg::SERV_HIGH: st_next.serv = irq_regs_pkg::SERV_HIGH;
                irq_regs_pkg::SERV_HIGH_OVER_LOW: st_next.serv = irq_regs_pkg::SERV_HIGH_OVER_LOW;
            endcase
        end else if (cpu_reti_i) begin
            unique case (st_reg.serv)
                irq_regs_pkg::SERV_IDLE: st_next.serv = irq_regs_pkg::SERV_IDLE;
                irq_regs_pkg::SERV_LOW: st_next.serv = irq_regs_pkg::SERV_IDLE;
                irq_regs_pkg::SERV_HIGH: st_next.serv = irq_regs_pkg::SERV_IDLE;
                irq_regs_pkg::SERV_HIGH_OVER_LOW: st_next.serv = irq_regs_pkg::SERV_LOW;
            endcase
        end

        // one full instruction must retire after a return
        st_next.holdoff = cpu_reti_i | (st_reg.holdoff & ~cpu_instr_done_i); // RULE22

        // re-resolved every cycle; a taken vector drops the request so
        // the same source is not presented twice while its flag clears
        st_next.req = res.grant_valid & grant_allowed & ~st_next.holdoff
                      & ~cpu_vector_ack_i; // RULE21 RULE22
        st_next.idx = res.grant_idx;
        st_next.level = res.grant_level;

        if (!reset_n_i) begin
            st_next.enable_main = `ENABLE_MAIN_RESET;
            st_next.priority_main = 7'(`PRIORITY_MAIN_RESET);
            st_next.enable_ext = `ENABLE_EXT_RESET;
            st_next.priority_ext = `PRIORITY_EXT_RESET;
            st_next.serv = irq_regs_pkg::SERV_IDLE;
            st_next.holdoff = 1'b0;
            st_next.req = 1'b0;
            st_next.idx = 4'h0;
            st_next.level = 1'b0;
            st_next.rdata = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st_reg <= st_next;
    end

    // ======================================================================
    // outputs
    assign sfr_rdata_o = st_reg.rdata;
    assign irq_req_o = st_reg.req;
    assign irq_idx_o = st_reg.idx;
    assign irq_level_o = st_reg.level;
    assign global_irq_gate_o = global_irq_gate;

    // ======================================================================
    // checks
    sequence reti_taken_s;
        cpu_reti_i;
    endsequence

    // second cycle may request only if an instruction retired just before
    sequence quiet_until_instr_s;
        !irq_req_o ##1 (!irq_req_o || $past(cpu_instr_done_i));
    endsequence

    gate_blocks_all_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE1
        !global_irq_gate && !sfr_wr_i |=> !irq_req_o [*2])
        else $error("request raised with global gate off");

    serial_mask_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE2
        !st_reg.enable_main[6] |=> !(irq_req_o && irq_idx_o == `SRC_SERIAL_PORT))
        else $error("masked serial port request delivered");

    timer2_either_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE3
        timer2_high_overflow_flag_i && !timer2_low_overflow_flag_i && global_irq_gate
        && st_reg.enable_main[5] |-> gated_vec[`SRC_TIMER2])
        else $error("timer 2 high flag did not request");

    uart_mask_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE4
        !st_reg.enable_main[4] |=> !(irq_req_o && irq_idx_o == `SRC_UART))
        else $error("masked uart request delivered");

    prio_top_one_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE8
        sfr_rd_i && sfr_addr_i == `PRIORITY_MAIN_ADDR |=> sfr_rdata_o[`PRIORITY_UNUSED_BIT])
        else $error("unused priority bit read as zero");

    match_mask_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE11
        !st_reg.enable_ext[7] |=> !(irq_req_o && irq_idx_o == `SRC_PORT_MATCH))
        else $error("masked port match request delivered");

    sample_each_cycle_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE21
        res.grant_valid && st_reg.serv == irq_regs_pkg::SERV_IDLE && !st_reg.holdoff
        && !cpu_reti_i && !cpu_vector_ack_i |=> irq_req_o && irq_idx_o == $past(res.grant_idx))
        else $error("idle pending request not presented next cycle");

    reti_holdoff_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE22
        reti_taken_s |=> quiet_until_instr_s)
        else $error("vector offered before instruction after return");

    high_blocks_all_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE23
        st_reg.serv == irq_regs_pkg::SERV_HIGH |-> !irq_req_o)
        else $error("request offered during high-level service");

    low_admits_high_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE23
        irq_req_o && st_reg.serv == irq_regs_pkg::SERV_LOW |-> irq_level_o)
        else $error("low request offered during low-level service");

endmodule : irq_mask_priority_regs

`default_nettype wire

/* testbench/cpu_vector_model.sv */
/*
 * Stand-in for the cpu vectoring logic: takes a presented request, runs a
 * short service, returns and retires one instruction before the next vector.
 * Assumes the block under test drives irq_req_i from a register.
 */
`timescale 1ns/100ps
`default_nettype none

module cpu_vector_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // bench control
    input wire logic enable_i,
    input wire logic slow_i,
    // request from the block
    input wire logic irq_req_i,
    // vectoring strobes
    output logic cpu_vector_ack_o,
    output logic cpu_reti_o,
    output logic cpu_instr_done_o
);
    int seen;
    int depth;
    int svc;
    int post;

    // ======================================================================
    // ack in the same cycle as the request it answers, never a stale one;
    // a core busy returning does not vector in that same cycle
    assign cpu_vector_ack_o = enable_i && irq_req_i && !cpu_reti_o
                              && (seen >= (slow_i ? 3 : 0));

    always @(posedge sys_clk_i) begin
        cpu_reti_o <= 1'b0;
        cpu_instr_done_o <= 1'b0;
        if (!reset_n_i) begin
            seen <= 0;
            depth <= 0;
            svc <= 0;
            post <= 0;
        end else begin
            seen <= (irq_req_i && !cpu_vector_ack_o) ? seen + 1 : 0;
            if (cpu_vector_ack_o) begin
                depth <= depth + 1;
                svc <= 6;
            end else if (svc > 1) begin
                svc <= svc - 1;
            end else if (svc == 1) begin
                cpu_reti_o <= 1'b1;
                depth <= depth - 1;
                svc <= 0;
                post <= 2;
            end
            // one instruction retires after each return
            if (post > 1) begin
                post <= post - 1;
            end else if (post == 1) begin
                cpu_instr_done_o <= 1'b1;
                post <= 0;
                if (depth > 0) begin
                    svc <= 6;
                end
            end
        end
    end
endmodule : cpu_vector_model

`default_nettype wire

/* testbench/tb_top.sv */
/*
 * Self-checking bench of the interrupt enable and priority registers,
 * with a behavioural model compared against read data and gate each cycle, and request, source and level once stimulus has settled.
 * Assumes the map header and the cpu vectoring model are compiled alongside.
 */
`timescale 1ns/100ps
`default_nettype none

`include "irq_regs_map.svh"

module tb_top;
    logic sys_clk_i, reset_n_i, sfr_wr_i, sfr_rd_i, p_en, p_slow;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    logic [15:0] flags, flags_q, nf;
    logic ack, reti, done, irq_req_o, irq_level_o, gate_o;
    logic [3:0] irq_idx_o;
    int error_cnt, n_checks, quiet, m_serv;
    logic [7:0] m_ie, m_ip, m_eie, m_eip, m_rd;
    logic m_req, m_lvl, m_hold;
    logic [3:0] m_idx;
    logic [14:0] pend, mask, lvl, src;
    logic [31:0] r;
    logic [7:0] addrs [5] = '{`ENABLE_MAIN_ADDR, `PRIORITY_MAIN_ADDR, `ENABLE_EXT_ADDR,
                              `PRIORITY_EXT_ADDR, 8'hA9};

    // ======================================================================
    // reference model
    always_comb begin
        pend = flags[14:0];
        pend[5] = flags[5] | flags[15];
        mask = {m_eie, m_ie[6:0]} & {15{m_ie[7]}};
        lvl = {m_eip, m_ip[6:0]};
    end

    function automatic int pick(input logic [14:0] p, input logic [14:0] l, input logic blk,
                                input int serv);
        int w;
        w = -1;
        for (int i = 14; i >= 0; i--) if (p[i] && l[i] && serv < 2) w = i;
        if (w < 0 && serv == 0) for (int i = 14; i >= 0; i--) if (p[i] && !l[i]) w = i;
        return blk ? -1 : w;
    endfunction : pick

    function automatic logic [7:0] rdval(input logic [7:0] a);
        case (a)
            `ENABLE_MAIN_ADDR: return m_ie;
            `PRIORITY_MAIN_ADDR: return m_ip;
            `ENABLE_EXT_ADDR: return m_eie;
            `PRIORITY_EXT_ADDR: return m_eip;
            default: return `UNMAPPED_READ;
        endcase
    endfunction : rdval

    always @(posedge sys_clk_i) begin
        int w;
        w = pick(pend & mask, lvl, m_hold && !done, m_serv);
        flags_q <= flags;
        // request, source and level are only judged once stimulus has settled for two cycles
        quiet <= (!reset_n_i || sfr_wr_i || ack || reti || done || flags != flags_q) ? 0
                 : (quiet < 9 ? quiet + 1 : quiet);
        if (!reset_n_i) begin
            m_ie <= `ENABLE_MAIN_RESET;
            m_ip <= `PRIORITY_MAIN_RESET;
            m_eie <= `ENABLE_EXT_RESET;
            m_eip <= `PRIORITY_EXT_RESET;
            m_rd <= 8'h00;
            m_req <= 1'b0;
            m_idx <= 4'h0;
            m_lvl <= 1'b0;
            m_hold <= 1'b0;
            m_serv <= 0;
        end else begin
            if (sfr_wr_i) begin
                case (sfr_addr_i)
                    `ENABLE_MAIN_ADDR: m_ie <= sfr_wdata_i;
                    `PRIORITY_MAIN_ADDR: m_ip <= {1'b1, sfr_wdata_i[6:0]};
                    `ENABLE_EXT_ADDR: m_eie <= sfr_wdata_i;
                    `PRIORITY_EXT_ADDR: m_eip <= sfr_wdata_i;
                    default: ;
                endcase
            end
            if (sfr_rd_i) m_rd <= rdval(sfr_addr_i);
            m_req <= (w >= 0) && !ack && !reti;
            if (w >= 0) m_idx <= w[3:0];
            if (w >= 0) m_lvl <= lvl[w];
            if (ack) m_serv <= m_lvl ? ((m_serv == 1) ? 3 : 2) : 1;
            if (reti) m_serv <= (m_serv == 3) ? 1 : 0;
            if (reti) m_hold <= 1'b1;
            else if (done) m_hold <= 1'b0;
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (exp !== got) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    always @(negedge sys_clk_i) begin
        if (reset_n_i) begin
            check("read data", m_rd, sfr_rdata_o);
            check("global gate", {7'h00, m_ie[7]}, {7'h00, gate_o});
            if (quiet >= 2) check("request", {7'h00, m_req}, {7'h00, irq_req_o});
            if (quiet >= 2 && m_req) check("source", {4'h0, m_idx}, {4'h0, irq_idx_o});
            if (quiet >= 2 && m_req) check("level", {7'h00, m_lvl}, {7'h00, irq_level_o});
        end
    end

    // ======================================================================
    // register port and closing
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        sfr_wr_i <= 1'b0;
    endtask : sfr_write

    task automatic reg_sweep(input logic [7:0] d, input logic wr);
        for (int i = 0; i < 5; i++) if (wr) sfr_write(addrs[i], d);
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk_i);
            sfr_addr_i <= addrs[i];
            sfr_rd_i <= 1'b1;
            @(posedge sys_clk_i);
            sfr_rd_i <= 1'b0;
            @(negedge sys_clk_i);
            check("register", i == 4 ? `UNMAPPED_READ : (i == 1 ? {1'b1, d[6:0]} : d),
                  sfr_rdata_o);
        end
    endtask : reg_sweep

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        {reset_n_i, sfr_wr_i, sfr_rd_i, p_en, p_slow} = 5'h00;
        {sfr_addr_i, sfr_wdata_i, flags} = 32'h0000_0000;
        error_cnt = 0;
        n_checks = 0;
        r = $urandom(32'h5fd1);
        repeat (6) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        reg_sweep(8'h00, 1'b0);
        reg_sweep(8'hFF, 1'b1);
        reg_sweep(8'h00, 1'b1);
        $display("test registers done");
        // one mask and one level at a time, with every other flag raised
        for (int i = 0; i < 15; i++) begin
            for (int l = 0; l < 2; l++) begin
                src = 15'h0001 << i;
                sfr_write(`ENABLE_MAIN_ADDR, {1'b1, src[6:0]});
                sfr_write(`ENABLE_EXT_ADDR, src[14:7]);
                sfr_write(`PRIORITY_MAIN_ADDR, l ? {1'b0, src[6:0]} : 8'h00);
                sfr_write(`PRIORITY_EXT_ADDR, l ? src[14:7] : 8'h00);
                flags <= (i == 5) ? (l ? 16'hFFDF : 16'h7FFF) : 16'hFFFF;
                repeat (3) @(posedge sys_clk_i);
                @(negedge sys_clk_i);
                check("swept request", 8'h01, {7'h00, irq_req_o});
                check("swept source", i[7:0], {4'h0, irq_idx_o});
                check("swept level", l[7:0], {7'h00, irq_level_o});
                sfr_write(`ENABLE_MAIN_ADDR, {1'b0, src[6:0]});
                repeat (3) @(posedge sys_clk_i);
                @(negedge sys_clk_i);
                check("gated request", 8'h00, {7'h00, irq_req_o});
                @(posedge sys_clk_i);
                flags <= 16'h0000;
            end
        end
        $display("test masks and levels done");
        p_en <= 1'b1;
        sfr_write(`ENABLE_EXT_ADDR, 8'hFF);
        for (int c = 0; c < 6000; c++) begin
            @(posedge sys_clk_i);
            r = $urandom;
            nf = flags;
            // the peripheral clears its own flag once vectored
            if (ack) nf[m_idx] = 1'b0;
            if (ack && m_idx == 4'h5) nf[15] = 1'b0;
            if (r[3:0] == 4'h0) nf[r[7:4]] = 1'b1;
            flags <= nf;
            sfr_wr_i <= (r[12:8] == 5'h00);
            sfr_rd_i <= r[13];
            sfr_addr_i <= addrs[r[16:14] % 5];
            sfr_wdata_i <= {r[17] | r[18], r[30:24]};
            p_slow <= r[19];
        end
        sfr_wr_i <= 1'b0;
        sfr_rd_i <= 1'b0;
        $display("test random traffic done");
        results();
    end

    irq_mask_priority_regs uut (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i),
        .sfr_wdata_i(sfr_wdata_i),
        .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o),
        .ext_pin0_request_i(flags[0]),
        .timer0_overflow_flag_i(flags[1]),
        .ext_pin1_request_i(flags[2]),
        .timer1_overflow_flag_i(flags[3]),
        .uart_request_i(flags[4]),
        .timer2_low_overflow_flag_i(flags[5]),
        .timer2_high_overflow_flag_i(flags[15]),
        .serial_port_request_i(flags[6]),
        .window_compare_flag_i(flags[7]),
        .conversion_done_flag_i(flags[8]),
        .counter_array_request_i(flags[9]),
        .comparator_fall_request_i(flags[10]),
        .comparator_rise_request_i(flags[11]),
        .lin_unit_request_i(flags[12]),
        .regulator_drop_request_i(flags[13]),
        .port_match_request_i(flags[14]),
        .cpu_vector_ack_i(ack),
        .cpu_reti_i(reti),
        .cpu_instr_done_i(done),
        .irq_req_o(irq_req_o),
        .irq_idx_o(irq_idx_o),
        .irq_level_o(irq_level_o),
        .global_irq_gate_o(gate_o)
    );

    cpu_vector_model cpu (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(p_en),
        .slow_i(p_slow),
        .irq_req_i(irq_req_o),
        .cpu_vector_ack_o(ack),
        .cpu_reti_o(reti),
        .cpu_instr_done_o(done)
    );
endmodule : tb_top

`default_nettype wire
